// ---- dv/tb_top.sv ----
/*
  tb_top: random self-checking bench for tims_top over APB.
  Assumes the design answers APB by itself and IRQ follows the state.
*/
`timescale 1ns/1ps
module tb_top;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        ce = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [10:0] fire = 11'h000;
  logic [31:0] prdata, rd, raw_m, mask_m, c;
  logic [31:0] seed = 32'h00009B19;
  logic [10:0] events;
  logic        pready, pslverr, irq, err;
  int          mismatches = 0;
  int          compares = 0;

  always #10 clk = ~clk;

  // clock enable is dropped once to show that state freezes
  tims_top uut (.CLK(clk), .SRST(srst), .CE(ce), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .EVENTS(events), .IRQ(irq));
  tims_evt_src src (.clk(clk), .fire_in(fire), .evt(events));

  function automatic logic [31:0] rnd(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    if (mismatches == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // one transfer; the idle edge at the end keeps strobes apart
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      mismatches++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask

  // read mask, raw, masked and the interrupt line against the model
  task automatic chk_all;
    bus(1'b0, tims_pkg::OFF_MASK, 32'h0); chk(rd, mask_m);
    bus(1'b0, tims_pkg::OFF_RAW, 32'h0); chk(rd, raw_m);
    bus(1'b0, tims_pkg::OFF_MSKD, 32'h0); chk(rd, raw_m & mask_m);
    chk({31'h0, irq}, {31'h0, |(raw_m & mask_m)});
  endtask

  initial begin
    raw_m = 32'h0;
    mask_m = 32'h0;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk_all();
    for (int i = 0; i < 40; i++) begin
      seed = rnd(seed);
      bus(1'b1, tims_pkg::OFF_MASK, seed);
      mask_m = seed & tims_pkg::IMPL_MASK;
      seed = rnd(seed);
      // bits 7:4 are fed too; they must be ignored
      fire <= seed[10:0];
      @(posedge clk);
      fire <= 11'h000;
      repeat (2) @(posedge clk);
      raw_m = raw_m | ({21'h0, seed[10:0]} & tims_pkg::IMPL_MASK);
      chk_all();
      bus(1'b1, tims_pkg::OFF_RAW, 32'hFFFFFFFF);
      chk({31'h0, err}, 32'h00000001);
      seed = rnd(seed);
      c = seed;
      bus(1'b1, tims_pkg::OFF_CLEAR, c);
      raw_m = raw_m & ~c;
    end
    // clear register reads zero without an error
    bus(1'b0, tims_pkg::OFF_CLEAR, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h0);
    // set beats clear: the pulse meets the clear's access edge
    bus(1'b1, tims_pkg::OFF_CLEAR, 32'h00000004);
    raw_m = raw_m & ~32'h00000004;
    fork
      bus(1'b1, tims_pkg::OFF_CLEAR, 32'h00000004);
      begin
        fire <= 11'h004;
        @(posedge clk);
        fire <= 11'h000;
      end
    join
    raw_m = raw_m | 32'h00000004;
    chk_all();
    // frozen clock enable: a pulse arriving meanwhile is lost
    ce <= 1'b0;
    fire <= 11'h70F;
    @(posedge clk);
    fire <= 11'h000;
    repeat (3) @(posedge clk);
    ce <= 1'b1;
    @(posedge clk);
    chk_all();
    bus(1'b0, 12'h02C, 32'h0);
    chk({31'h0, err}, 32'h00000001);
    chk(rd, 32'h0);
    // reset in mid-run must drop mask and status again
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    raw_m = 32'h0;
    mask_m = 32'h0;
    chk_all();
    complete_run();
  end
endmodule // tb_top

// ---- dv/tims_evt_src.sv ----
/*
  tims_evt_src: model of the timer core that raises event pulses.
  Assumes the bench sets fire_in for one cycle per burst of events.
*/
`timescale 1ns/1ps
module tims_evt_src (
  input  wire logic        clk,
  input  wire logic [10:0] fire_in,
  output logic      [10:0] evt = 11'h000
);
  // registered one-cycle pulses, as a time-out or capture would give
  always @(posedge clk) begin
    evt <= fire_in;
  end
endmodule // tims_evt_src

// ---- hw/tims_pkg.sv ----
/*
  tims_pkg: register map, field positions and bus carrier types for the
  timer interrupt mask and status block.
  Assumes a 32-bit APB with byte addresses and one word per register.
*/
package tims_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 12;

  // byte offsets of the registers
  localparam logic [11:0] OFF_MASK  = 12'h018;
  localparam logic [11:0] OFF_RAW   = 12'h01C;
  localparam logic [11:0] OFF_MSKD  = 12'h020;
  localparam logic [11:0] OFF_CLEAR = 12'h024;

  // field positions shared by mask, raw, masked and clear registers
  localparam int unsigned BIT_FIRST_TIMEOUT  = 0;
  localparam int unsigned BIT_FIRST_CAP_MTCH = 1;
  localparam int unsigned BIT_FIRST_CAP_EVT  = 2;
  localparam int unsigned BIT_CLOCK_MATCH    = 3;
  localparam int unsigned BIT_SECOND_TIMEOUT = 8;
  localparam int unsigned BIT_SECOND_CAP_MTC = 9;
  localparam int unsigned BIT_SECOND_CAP_EVT = 10;

  // implemented bits: 10:8 and 3:0, reserved 31:11 and 7:4 read zero
  localparam logic [31:0] IMPL_MASK  = 32'h0000070F;
  localparam logic [31:0] RESET_MASK = 32'h00000000;
  localparam logic [31:0] RESET_RAW  = 32'h00000000;

  // apb request as seen by the slave
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } tims_apb_req_type;

endpackage : tims_pkg

// ---- hw/tims_top.sv ----
/*
  tims_top: interrupt mask, raw status and masked status for a two-half
  general timer with a clock-match event, reached over APB.
  Assumes event inputs are one-cycle pulses synchronous to CLK and that
  the system interrupt controller samples IRQ as a level.
*/
// The APB interface to the registers was left to the implementer.
// What this block does
// - a mask bit written one enables its source, written zero disables it.
// - mask bits 0..3 enable first timeout, first match, first event, clock.
// - mask bits 8..10 enable second timeout, second match, second event.
// - bits 31:11 and 7:4 of all registers are reserved and not writable.
// - after reset all mask bits and all status bits are zero.
// - a raw status bit sets on its event whatever its mask bit holds.
// - a raw bit clears only by writing one to it in the clear register.
// - raw bits 10, 9, 8 report second event, match and timeout.
// - raw bits 3..0 report clock match, first event, match and timeout.
// - a masked bit reads one only when raw and mask bits are both one.
// - a one written to the clear register clears masked status too.
// - the masked register is read-only with the raw register's layout.
// - the clear register at 0x024 is write-one-to-clear, zeros no effect.
`timescale 1ns/1ps

module tims_top (
  input  wire logic        CLK,
  input  wire logic        SRST,
  input  wire logic        CE,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic [10:0] EVENTS,
  output logic             IRQ
);

  tims_pkg::tims_apb_req_type req;
  logic [31:0] mask_q;
  logic [31:0] mask_d;
  logic [31:0] raw_q;
  logic [31:0] raw_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        pready_q;
  logic        pslverr_q;
  logic        pslverr_d;
  logic        irq_q;
  logic        irq_d;

  // a word is valid only if it hits one of the four register offsets
  function automatic logic addr_hit(input logic [11:0] a,
                                    input logic [11:0] off);
    addr_hit = (a == off);
  endfunction

  // bus request bundled for decoding
  assign req = '{sel: PSEL, enable: PENABLE, write: PWRITE,
                 addr: PADDR, wdata: PWDATA};

  // access phase with zero wait states: pready is raised by the flop
  // one cycle after setup, so the transfer completes in the access cycle
  wire access   = req.sel & req.enable & pready_q;
  wire hit_mask = addr_hit(req.addr, tims_pkg::OFF_MASK);
  wire hit_raw  = addr_hit(req.addr, tims_pkg::OFF_RAW);
  wire hit_mskd = addr_hit(req.addr, tims_pkg::OFF_MSKD);
  wire hit_clr  = addr_hit(req.addr, tims_pkg::OFF_CLEAR);
  wire hit_any  = hit_mask | hit_raw | hit_mskd | hit_clr;
  wire wr_mask  = access & req.write & hit_mask;
  wire wr_clr   = access & req.write & hit_clr;

  // events padded into register layout; reserved lanes never set
  wire [31:0] evt_word = {21'h000000, EVENTS[10:8], 4'h0, EVENTS[3:0]};
  wire [31:0] clr_word = wr_clr ? (req.wdata & tims_pkg::IMPL_MASK)
                                : 32'h00000000;
  wire [31:0] masked   = raw_q & mask_q;

  // mask write keeps reserved bits at zero; a read-modify-write by
  // software therefore sees zeros there and writes them back unchanged
  assign mask_d = wr_mask ? (req.wdata & tims_pkg::IMPL_MASK)
                          : mask_q;

  // set beats clear in the same cycle so no event is lost
  assign raw_d = ((raw_q & ~clr_word) | evt_word)
                 & tims_pkg::IMPL_MASK;

  // read mux; clear register reads as zero, unmapped reads zero
  assign prdata_d = !(req.sel & ~req.enable & ~req.write) ? prdata_q :
                    hit_mask ? mask_q :
                    hit_raw  ? raw_q :
                    hit_mskd ? masked : 32'h00000000;
  // error on unmapped address, and on writes to read-only status
  assign pslverr_d = req.sel & ~req.enable &
                     (~hit_any | (req.write & (hit_raw | hit_mskd)));

  // interrupt follows the next-state masked status so it is a flop output
  assign irq_d = |(raw_d & mask_d);

  // register state; clock enable freezes everything, bus answer too,
  // so a transfer is not stretched: a low enable at its setup edge never
  // raises PREADY, and at its access edge the held PREADY ends a write
  // unstored; reset does not look at the enable, so it always lands
  always_ff @(posedge CLK) begin
    if (SRST) begin
      mask_q    <= tims_pkg::RESET_MASK;
      raw_q     <= tims_pkg::RESET_RAW;
      prdata_q  <= 32'h00000000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      irq_q     <= 1'b0;
    end else if (CE) begin
      mask_q    <= mask_d;
      raw_q     <= raw_d;
      prdata_q  <= prdata_d;
      pready_q  <= req.sel & ~req.enable;
      pslverr_q <= req.sel & ~req.enable ? pslverr_d
                                         : pslverr_q & req.enable;
      irq_q     <= irq_d;
    end
  end

  assign PRDATA  = prdata_q;
  assign PREADY  = pready_q;
  assign PSLVERR = pslverr_q;
  assign IRQ     = irq_q;

  // the checks below, except a_reset_clear, are off while reset is held: reset may land in the
  // middle of a transfer and leave the bus half done; most of them only
  // look at enabled cycles, since a low enable freezes every flop

  // one bit of a clear write, used as a step of a_clear_bit
  sequence s_clear_write(int b);
    wr_clr && req.wdata[b];
  endsequence

  // setup cycle of any transfer, taken at an enabled edge
  sequence s_setup;
    CE && PSEL && !PENABLE;
  endsequence

  // setup cycle of a write to the registers that hit selects
  sequence s_setup_write(hit);
    CE && PSEL && !PENABLE && PWRITE && hit;
  endsequence

  // access cycle of a read; the answer was latched at the setup edge,
  // so it is held against what the registers showed one cycle back
  sequence s_read_done(hit);
    PSEL && PENABLE && PREADY && !PWRITE && hit && $past(CE);
  endsequence

  // mask register
  a_mask_write:
    assert property (@(posedge CLK) disable iff (SRST)
    CE && wr_mask |=> mask_q == ($past(req.wdata) & tims_pkg::IMPL_MASK))
    else $error("mask write not stored");

  a_mask_hold:
    assert property (@(posedge CLK) disable iff (SRST)
    CE && !wr_mask |=> mask_q == $past(mask_q))
    else $error("mask changed without a mask write");

  a_mask_low:
    assert property (@(posedge CLK) disable iff (SRST)
    CE && wr_mask |=> mask_q[3:0] == $past(req.wdata[3:0]))
    else $error("low mask bits not stored");

  a_mask_high:
    assert property (@(posedge CLK) disable iff (SRST)
    CE && wr_mask |=> mask_q[10:8] == $past(req.wdata[10:8]))
    else $error("high mask bits not stored");

  a_mask_bits:
    assert property (@(posedge CLK) disable iff (SRST)
    CE && wr_mask && req.wdata[8] && !wr_clr ##1 raw_q[8]
    |-> IRQ)
    else $error("enabled second timeout did not interrupt");

  // reserved lanes and bus answers
  a_reserved_zero:
    assert property (@(posedge CLK) disable iff (SRST)
    ((mask_q | raw_q) & ~tims_pkg::IMPL_MASK) == 32'h00000000)
    else $error("reserved bit set");

  a_slverr_ro:
    assert property (@(posedge CLK) disable iff (SRST)
    s_setup_write(hit_raw || hit_mskd) |=> PSLVERR)
    else $error("write to status register not flagged");

  a_slverr_map: // unmapped offset
    assert property (@(posedge CLK) disable iff (SRST)
    s_setup ##0 !hit_any |=> PSLVERR)
    else $error("unmapped access not flagged");

  a_pready_once: // zero wait states
    assert property (@(posedge CLK) disable iff (SRST)
    s_setup |=> PREADY)
    else $error("no answer in the access cycle");

  // reset and clock enable
  a_reset_clear:
    assert property (@(posedge CLK)
    $past(SRST) |-> mask_q == 32'h0 && raw_q == 32'h0 && !IRQ)
    else $error("state not cleared by reset");

  a_freeze_state: // clock enable low
    assert property (@(posedge CLK) disable iff (SRST)
    !CE |=> mask_q == $past(mask_q) && raw_q == $past(raw_q)
            && IRQ == $past(IRQ))
    else $error("state moved while enable low");

  // events into raw status
  a_event_sets:
    assert property (@(posedge CLK) disable iff (SRST)
    CE && EVENTS[0] |=> raw_q[tims_pkg::BIT_FIRST_TIMEOUT])
    else $error("first timeout event lost");

  a_event_match:
    assert property (@(posedge CLK) disable iff (SRST)
    CE && EVENTS[1] |=> raw_q[tims_pkg::BIT_FIRST_CAP_MTCH])
    else $error("first capture match lost");

  a_event_first:
    assert property (@(posedge CLK) disable iff (SRST)
    CE && EVENTS[2] |=> raw_q[tims_pkg::BIT_FIRST_CAP_EVT])
    else $error("first capture event lost");

  a_event_clock:
    assert property (@(posedge CLK) disable iff (SRST)
    CE && EVENTS[3] |=> raw_q[tims_pkg::BIT_CLOCK_MATCH])
    else $error("clock match event lost");

  a_event_second:
    assert property (@(posedge CLK) disable iff (SRST)
    CE && EVENTS[8] |=> raw_q[tims_pkg::BIT_SECOND_TIMEOUT])
    else $error("second timeout event lost");

  a_event_smatch:
    assert property (@(posedge CLK) disable iff (SRST)
    CE && EVENTS[9] |=> raw_q[tims_pkg::BIT_SECOND_CAP_MTC])
    else $error("second capture match lost");

  a_event_high:
    assert property (@(posedge CLK) disable iff (SRST)
    CE && EVENTS[10] |=> raw_q[tims_pkg::BIT_SECOND_CAP_EVT])
    else $error("second capture event lost");

  a_event_masked:
    assert property (@(posedge CLK) disable iff (SRST)
    CE && EVENTS[3] && !mask_q[3] |=> raw_q[tims_pkg::BIT_CLOCK_MATCH])
    else $error("masked event not latched in raw status");

  // clearing raw and masked status
  a_raw_hold:
    assert property (@(posedge CLK) disable iff (SRST)
    CE && raw_q[3] && !(wr_clr && req.wdata[3]) |=> raw_q[3])
    else $error("raw bit cleared without a clear write");

  a_raw_ro:
    assert property (@(posedge CLK) disable iff (SRST)
    CE && access && PWRITE && hit_raw |=> ($past(raw_q) & ~raw_q) == 32'h0)
    else $error("write to raw status cleared a bit");

  a_clear_bit:
    assert property (@(posedge CLK) disable iff (SRST)
    s_clear_write(1) and (CE && !EVENTS[1]) |=> !raw_q[1] && !masked[1])
    else $error("clear write did not clear status");

  a_clear_keep:
    assert property (@(posedge CLK) disable iff (SRST)
    CE && wr_clr |=> ($past(raw_q) & ~$past(req.wdata) & ~raw_q) == 32'h0)
    else $error("zero in clear write dropped a status bit");

  // read answers
  a_masked_and:
    assert property (@(posedge CLK) disable iff (SRST)
    s_read_done(hit_mskd) |-> PRDATA == $past(raw_q & mask_q))
    else $error("masked read not raw and mask");

  a_mask_read:
    assert property (@(posedge CLK) disable iff (SRST)
    s_read_done(hit_mask) |-> PRDATA == $past(mask_q))
    else $error("mask read wrong");

  a_raw_read:
    assert property (@(posedge CLK) disable iff (SRST)
    s_read_done(hit_raw) |-> PRDATA == $past(raw_q))
    else $error("raw status read wrong");

  a_clear_read:
    assert property (@(posedge CLK) disable iff (SRST)
    s_read_done(hit_clr) |-> PRDATA == 32'h00000000)
    else $error("clear register read not zero");

  // interrupt line
  a_irq_level:
    assert property (@(posedge CLK) disable iff (SRST)
    IRQ == (|(raw_q & mask_q)))
    else $error("irq does not follow masked status");

  a_irq_event:
    assert property (@(posedge CLK) disable iff (SRST)
    CE && EVENTS[2] && mask_q[2] && !wr_mask |=> IRQ)
    else $error("enabled event did not interrupt");

endmodule // tims_top
